//--- rtl/flash_prot_host.sv
`timescale 1ns/1ps
`default_nettype none

module flash_prot_host (
    input  wire logic                                   i_ref_clk,
    input  wire logic                                   i_resetn,
    input  wire logic                                   i_req_valid,
    input  wire flash_prot_host_pkg::req_t              i_req,
    input  wire logic                                   i_temp_unprotect,
    input  wire logic                                   i_supply_ok,
    input  wire logic [flash_prot_host_pkg::DATA_W-1:0] i_dq,
    input  wire logic                                   i_operation_done_n,
    output logic                                        o_req_ready,
    output logic                                        o_rsp_valid,
    output logic [flash_prot_host_pkg::DATA_W-1:0]      o_rsp_data,
    output logic                                        o_group_protected,
    output flash_prot_host_pkg::pins_t                  o_pins
);
    import flash_prot_host_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_WAIT_DONE
    } state_t;

    typedef struct packed {
        state_t              state;
        req_t                req;
        logic [2:0]          cyc_idx;
        logic [2:0]          cyc_total;
        logic [CNT_W-1:0]    cnt;
        logic                ready;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rsp_data;
        logic                prot;
        pins_t               pins;
        logic [DATA_W-1:0]   dq_s1;
        logic [DATA_W-1:0]   dq_s2;
        logic [1:0]          ok_s;
        logic [1:0]          done_s;
    } host_state_t;

    host_state_t s_reg;
    host_state_t s_next;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic is_read(input op_t op, input logic hv);
        is_read = (op == OP_READ) || (hv && op inside {OP_READ_ID_MAKER, OP_READ_ID_PART,
                                                         OP_VERIFY_GROUP});
    endfunction : is_read

    function automatic logic [2:0] cycles_of(input op_t op, input logic hv);
        unique case (op)
            OP_READ_ID_MAKER, OP_READ_ID_PART, OP_VERIFY_GROUP:
                cycles_of = hv ? 3'd1 : 3'd4;
            OP_PROGRAM:      cycles_of = 3'd4;
            OP_ERASE_SECTOR: cycles_of = 3'd6;
            OP_READ, OP_RESET_CMD: cycles_of = 3'd1;
            default:         cycles_of = 3'd1;
        endcase
    endfunction : cycles_of

    // Autoselect address: A6 low, A1/A0 select code, group on top bits
    function automatic logic [ADDR_W-1:0] id_addr(input req_t r);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[A6_POS] = 1'b0;
        a[A1_POS] = (r.op == OP_VERIFY_GROUP);
        a[A0_POS] = (r.op == OP_READ_ID_PART);
        if (r.op == OP_VERIFY_GROUP)
            a[GROUP_LSB +: GROUP_W] = r.addr[GROUP_LSB +: GROUP_W];
        id_addr = a;
    endfunction : id_addr

    function automatic void cycle_of(input req_t r, input logic [2:0] idx,
                                     output logic [ADDR_W-1:0] a,
                                     output logic [DATA_W-1:0] d);
        a = UNLOCK_ADDR_1;
        d = UNLOCK_DATA_1;
        unique case (idx)
            3'd0, 3'd3: begin
                a = UNLOCK_ADDR_1;
                d = UNLOCK_DATA_1;
            end
            3'd1, 3'd4: begin
                a = UNLOCK_ADDR_2;
                d = UNLOCK_DATA_2;
            end
            default: begin
                a = UNLOCK_ADDR_1;
                d = UNLOCK_DATA_1;
            end
        endcase
        if (idx == 3'd2) begin
            unique case (r.op)
                OP_PROGRAM:      d = CMD_PROGRAM;
                OP_ERASE_SECTOR: d = CMD_ERASE;
                default:         d = CMD_AUTOSELECT;
            endcase
        end
        if (r.op == OP_PROGRAM && idx == 3'd3) begin
            a = r.addr;
            d = r.data;
        end
        if (r.op == OP_ERASE_SECTOR && idx == 3'd5) begin
            a = r.addr;
            d = CMD_SECTOR_ERASE;
        end
        if (r.op == OP_RESET_CMD) begin
            a = '0;
            d = CMD_RESET;
        end
    endfunction : cycle_of

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic              rd;
        logic              last;
        logic [ADDR_W-1:0] ca;
        logic [DATA_W-1:0] cd;
        rd     = is_read(s_reg.req.op, s_reg.req.hv_method);
        last   = (s_reg.cyc_idx + 3'd1 == s_reg.cyc_total);
        ca     = '0;
        cd     = '0;
        s_next = s_reg;
        s_next.dq_s1  = i_dq;
        s_next.dq_s2  = s_reg.dq_s1;
        s_next.ok_s   = {s_reg.ok_s[0], i_supply_ok};
        s_next.done_s = {s_reg.done_s[0], i_operation_done_n};
        s_next.rsp_valid = 1'b0;
        s_next.pins.reset_hv = i_temp_unprotect;
        if (s_reg.state != ST_IDLE)
            s_next.cnt = s_reg.cnt + CNT_W'(1);
        unique case (s_reg.state)
            ST_IDLE: begin
                s_next.pins.ce_n    = 1'b1;
                s_next.pins.we_n    = 1'b1;
                s_next.pins.oe_n    = 1'b1;
                s_next.pins.dq_oe_n = 1'b1;
                s_next.pins.a9_hv   = 1'b0;
                // Ready waits out the response pulse
                s_next.ready        = s_reg.ok_s[1] && !s_reg.rsp_valid;
                if (s_reg.ready && i_req_valid && s_reg.ok_s[1]) begin
                    s_next.req       = i_req;
                    s_next.ready     = 1'b0;
                    s_next.cyc_idx   = '0;
                    s_next.cyc_total = cycles_of(i_req.op, i_req.hv_method);
                    s_next.cnt       = '0;
                    s_next.state     = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address and OE settle before any strobe falls
                if (rd || (s_reg.req.op inside {OP_READ_ID_MAKER, OP_READ_ID_PART,
                           OP_VERIFY_GROUP} && s_reg.cyc_idx == s_reg.cyc_total - 3'd1)) begin
                    s_next.pins.addr    = s_reg.req.op == OP_READ ? s_reg.req.addr
                                                                  : id_addr(s_reg.req);
                    s_next.pins.a9_hv   = s_reg.req.hv_method;
                    s_next.pins.dq_oe_n = 1'b1;
                end else begin
                    cycle_of(s_reg.req, s_reg.cyc_idx, ca, cd);
                    s_next.pins.addr    = ca;
                    s_next.pins.dq_out  = cd;
                    s_next.pins.dq_oe_n = 1'b0;
                    s_next.pins.oe_n    = 1'b1;
                end
                if (s_reg.cnt == CNT_W'(PHASE_CYC - 1)) begin
                    s_next.cnt   = '0;
                    s_next.state = ST_STROBE;
                    s_next.pins.ce_n = 1'b0;
                    if (s_next.pins.dq_oe_n)
                        s_next.pins.oe_n = 1'b0;
                    else
                        s_next.pins.we_n = 1'b0;
                end
            end
            ST_STROBE: begin
                // Strobe width two cycles (80 ns), far above the glitch filter
                if (s_reg.cnt == CNT_W'(PHASE_CYC - 1)) begin
                    s_next.cnt       = '0;
                    s_next.state     = ST_HOLD;
                    s_next.pins.we_n = 1'b1;
                    s_next.pins.oe_n = 1'b1;
                    s_next.pins.ce_n = 1'b1;
                end
            end
            ST_HOLD: begin
                // Data sampled mid-strobe has now passed both sync stages
                if (s_reg.cnt == '0 && s_reg.pins.dq_oe_n) begin
                    s_next.rsp_data = s_reg.dq_s2;
                    s_next.prot     = s_reg.req.op == OP_VERIFY_GROUP
                                      && (s_reg.dq_s2 & PROT_BIT_MASK) != '0;
                    s_next.rsp_valid = 1'b1;
                end
                if (s_reg.cnt == CNT_W'(PHASE_CYC - 1)) begin
                    s_next.cnt       = '0;
                    s_next.pins.dq_oe_n = 1'b1;
                    s_next.pins.a9_hv   = 1'b0;
                    if (!last) begin
                        s_next.cyc_idx = s_reg.cyc_idx + 3'd1;
                        s_next.state   = ST_SETUP;
                    end else if (s_reg.req.op inside {OP_PROGRAM, OP_ERASE_SECTOR})
                        s_next.state = ST_WAIT_DONE;
                    else
                        s_next.state = ST_IDLE;
                end
            end
            ST_WAIT_DONE: begin
                // Busy flag rises late; give it a phase first
                if (s_reg.cnt >= CNT_W'(PHASE_CYC) && s_reg.done_s[1]) begin
                    s_next.rsp_valid = 1'b1;
                    s_next.rsp_data  = '0;
                    s_next.prot      = 1'b0;
                    s_next.state     = ST_IDLE;
                end
                if (s_reg.cnt == '1)
                    s_next.cnt = s_reg.cnt;
            end
        endcase
        if (!s_reg.ok_s[1] && s_reg.state != ST_IDLE) begin
            s_next.state        = ST_IDLE;
            s_next.pins.ce_n    = 1'b1;
            s_next.pins.we_n    = 1'b1;
            s_next.pins.oe_n    = 1'b1;
            s_next.pins.dq_oe_n = 1'b1;
            s_next.pins.a9_hv   = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_reg <= '{state: ST_IDLE, req: '0, cyc_idx: '0, cyc_total: '0, cnt: '0,
                       ready: 1'b0, rsp_valid: 1'b0, rsp_data: '0, prot: 1'b0,
                       pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, a9_hv: 1'b0,
                               reset_hv: 1'b0, addr: '0, dq_out: '0, dq_oe_n: 1'b1},
                       dq_s1: '0, dq_s2: '0, ok_s: '0, done_s: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_req_ready       = s_reg.ready;
    assign o_rsp_valid       = s_reg.rsp_valid;
    assign o_rsp_data        = s_reg.rsp_data;
    assign o_group_protected = s_reg.prot;
    assign o_pins            = s_reg.pins;

endmodule : flash_prot_host

`default_nettype wire

//--- rtl/flash_prot_host_pkg.sv
package flash_prot_host_pkg;

    localparam int ADDR_W            = 21;
    localparam int DATA_W            = 8;
    localparam int GROUP_W           = 3;
    localparam int GROUP_LSB         = 18;
    // Autoselect address bit positions
    localparam int A0_POS            = 0;
    localparam int A1_POS            = 1;
    localparam int A6_POS            = 6;
    // Bus phase timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int PHASE_NS          = 80;
    localparam int PHASE_CYC         = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W             = 4;
    // Unlock sequence, command codes and protect status bit mask
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 21'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 21'h0002AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_1 = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_AUTOSELECT = 8'h90;
    localparam logic [DATA_W-1:0] CMD_PROGRAM    = 8'hA0;
    localparam logic [DATA_W-1:0] CMD_ERASE      = 8'h80;
    localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [DATA_W-1:0] CMD_RESET      = 8'hF0;
    localparam logic [DATA_W-1:0] PROT_BIT_MASK  = 8'h01;

    typedef enum logic [2:0] {
        OP_READ_ID_MAKER,
        OP_READ_ID_PART,
        OP_VERIFY_GROUP,
        OP_PROGRAM,
        OP_ERASE_SECTOR,
        OP_READ,
        OP_RESET_CMD
    } op_t;

    typedef struct packed {
        op_t                 op;
        logic                hv_method;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } req_t;

    typedef struct packed {
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                a9_hv;
        logic                reset_hv;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe_n;
    } pins_t;

endpackage : flash_prot_host_pkg

//--- sim/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0] MAKER_CODE = 8'hC5, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h6E, // Arbitrary value
    parameter int         BUSY_NS    = 400
) (
    input  wire flash_prot_host_pkg::pins_t i_pins,
    input  wire logic                       i_supply_ok,
    input  wire logic [7:0]                 i_group_prot,
    output logic [7:0]                      o_dq,
    output logic                            o_operation_done_n
);
    import flash_prot_host_pkg::*;
    logic [7:0]      mem [int];
    logic [7:0]      rd_val;
    logic [7:0]      last_val = 8'h00;
    logic            autosel  = 1'b0;
    logic            armed    = 1'b0;
    int              step     = 0;
    realtime         t_fall;
    wire logic       wr  = !i_pins.ce_n && !i_pins.we_n && i_pins.oe_n;
    wire logic       rd  = !i_pins.ce_n && !i_pins.oe_n;
    wire logic [2:0] grp = i_pins.addr[20:18];
    initial o_operation_done_n = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic work(input logic [20:0] a, input logic erase, input logic [7:0] d);
        int ks[$];
        o_operation_done_n = 1'b0;
        if (!(i_group_prot[grp] && !i_pins.reset_hv)) begin
            if (erase) begin
                foreach (mem[k]) if (k[20:16] == a[20:16]) ks.push_back(k);
                foreach (ks[i]) mem.delete(ks[i]);
            end else mem[a] = d;
        end
        #(BUSY_NS) o_operation_done_n = 1'b1;
    endtask : work
    task automatic cmd(input logic [20:0] a, input logic [7:0] d);
        if (d == CMD_RESET) begin
            step    = 0;
            autosel = 1'b0;
        end else case (step)
            0, 3: step = (a[10:0] == UNLOCK_ADDR_1[10:0] && d == UNLOCK_DATA_1) ? step + 1 : 0;
            1, 4: step = (a[10:0] == UNLOCK_ADDR_2[10:0] && d == UNLOCK_DATA_2) ? step + 1 : 0;
            2: begin
                autosel = (d == CMD_AUTOSELECT);
                step = (d == CMD_PROGRAM) ? 6 : (d == CMD_ERASE) ? 3 : 0;
            end
            5: begin
                step = 0;
                if (d == CMD_SECTOR_ERASE) work(a, 1'b1, d);
            end
            6: begin
                step = 0;
                work(a, 1'b0, d);
            end
            default: step = 0;
        endcase
    endtask : cmd
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge wr) t_fall = $realtime;
    always @(negedge wr) begin
        if (!i_supply_ok || !armed || $realtime - t_fall < 5.0) step = 0;
        else cmd(i_pins.addr, i_pins.dq_out);
        armed = i_supply_ok;
    end
    always @(negedge i_supply_ok) begin
        step    = 0;
        autosel = 1'b0;
        armed   = 1'b0;
    end
    always @(posedge i_supply_ok) armed = !wr;
    always @* begin
        if (i_pins.a9_hv || autosel) begin
            case (i_pins.addr[1:0])
                2'b00:   rd_val = MAKER_CODE;
                2'b01:   rd_val = PART_CODE;
                default: rd_val = {7'h00, i_group_prot[grp]};
            endcase
        end else rd_val = mem.exists(i_pins.addr) ? mem[i_pins.addr] : 8'hFF;
        if (rd) last_val = rd_val;
    end
    assign o_dq = rd ? rd_val : ~last_val;
endmodule : flash_dev_model
`default_nettype wire

//--- sim/flash_prot_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module flash_prot_host_props (
    input wire logic                                   i_ref_clk,
    input wire logic                                   i_resetn,
    input wire logic                                   i_req_valid,
    input wire flash_prot_host_pkg::req_t              i_req,
    input wire logic                                   i_temp_unprotect,
    input wire logic                                   i_supply_ok,
    input wire logic [flash_prot_host_pkg::DATA_W-1:0] i_dq,
    input wire logic                                   i_operation_done_n,
    input wire logic                                   o_req_ready,
    input wire logic                                   o_rsp_valid,
    input wire logic [flash_prot_host_pkg::DATA_W-1:0] o_rsp_data,
    input wire logic                                   o_group_protected,
    input wire flash_prot_host_pkg::pins_t             o_pins
);
    import flash_prot_host_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    AST_WRITE_FORM: assert property (!o_pins.we_n |-> o_pins.oe_n && !o_pins.dq_oe_n)
        else $error("write strobe without output high or data driven");
    AST_READ_FORM: assert property (!o_pins.oe_n |-> o_pins.we_n && o_pins.dq_oe_n)
        else $error("read strobe while writing or driving data");
    AST_HV_ID_ADDR: assert property (o_pins.a9_hv && !o_pins.oe_n |->
        !o_pins.addr[A6_POS] && !(o_pins.addr[A1_POS] && o_pins.addr[A0_POS]))
        else $error("id address bits wrong under high voltage");
    AST_PROT_FLAG: assert property (o_group_protected |-> o_rsp_data[0])
        else $error("protected flag without low data bit");
    AST_WR_HOLD: assert property (!o_pins.ce_n && !o_pins.we_n |=>
        $stable(o_pins.addr) && $stable(o_pins.dq_out))
        else $error("address or data moved around write strobe");
    AST_STROBE_WIDTH: assert property ($fell(o_pins.we_n) |-> !o_pins.we_n [*2] ##1 o_pins.we_n)
        else $error("write strobe not two cycles");
    AST_TEMP_ON: assert property (i_temp_unprotect |=> o_pins.reset_hv)
        else $error("reset pin high voltage not applied");
    AST_TEMP_OFF: assert property (!i_temp_unprotect |=> !o_pins.reset_hv)
        else $error("reset pin high voltage not removed");
    AST_LOCKOUT_IDLE: assert property (!i_supply_ok [*5] |->
        o_pins.ce_n && o_pins.we_n && o_pins.oe_n && !o_req_ready)
        else $error("strobes active under low supply");
    AST_READY_IDLE: assert property (o_req_ready |-> o_pins.ce_n && o_pins.we_n && o_pins.oe_n)
        else $error("strobes active while idle");
    AST_RSP_PULSE: assert property (o_rsp_valid |=> !o_rsp_valid && !o_req_ready)
        else $error("response longer than one cycle");
    AST_TAKE: assert property (i_req_valid && o_req_ready |=> !o_req_ready [*3])
        else $error("ready not dropped after take");
endmodule : flash_prot_host_props
bind flash_prot_host flash_prot_host_props u_props (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_req_valid(i_req_valid), .i_req(i_req), .i_temp_unprotect(i_temp_unprotect),
    .i_supply_ok(i_supply_ok), .i_dq(i_dq), .i_operation_done_n(i_operation_done_n),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_group_protected(o_group_protected), .o_pins(o_pins));
`default_nettype wire

//--- sim/flash_prot_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_prot_host_tb_top;
    import flash_prot_host_pkg::*;
    typedef struct {op_t op; logic hv; logic [20:0] a; logic [7:0] exp; logic prot;} row_t;
    localparam logic [7:0] MAKER = 8'hC5; // Arbitrary value
    localparam logic [7:0] PART  = 8'h6E; // Arbitrary value
    logic       i_ref_clk, i_resetn, i_req_valid, i_temp_unprotect, i_supply_ok;
    logic       i_operation_done_n, o_req_ready, o_rsp_valid, o_group_protected, got;
    req_t       i_req;
    pins_t      o_pins;
    logic [7:0] i_dq, o_rsp_data, grp_prot;
    int         error_cnt = 0, checks_done = 0, n;
    row_t       rows [9] = '{'{OP_READ, 0, 21'h000040, 8'hFF, 0},
        '{OP_READ_ID_MAKER, 1, 0, MAKER, 0}, '{OP_READ_ID_PART, 1, 0, PART, 0},
        '{OP_VERIFY_GROUP, 1, 21'h000000, 8'h00, 0}, '{OP_VERIFY_GROUP, 1, 21'h140000, 8'h01, 1},
        '{OP_READ_ID_MAKER, 0, 0, MAKER, 0}, '{OP_READ_ID_PART, 0, 0, PART, 0},
        '{OP_VERIFY_GROUP, 0, 21'h1C0000, 8'h00, 0}, '{OP_VERIFY_GROUP, 0, 21'h140000, 8'h01, 1}};
    flash_prot_host dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
        .i_req(i_req), .i_temp_unprotect(i_temp_unprotect), .i_supply_ok(i_supply_ok),
        .i_dq(i_dq), .i_operation_done_n(i_operation_done_n), .o_req_ready(o_req_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
        .o_group_protected(o_group_protected), .o_pins(o_pins));
    flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.i_pins(o_pins),
        .i_supply_ok(i_supply_ok), .i_group_prot(grp_prot), .o_dq(i_dq),
        .o_operation_done_n(i_operation_done_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp);
        checks_done++;
        if (got_v !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got_v, exp);
        end
    endtask : chk
    task automatic do_req(input op_t op, input logic hv, input logic [20:0] a, input logic [7:0] d);
        i_req       = '{op: op, hv_method: hv, addr: a, data: d};
        i_req_valid = 1'b1;
        for (n = 0; n < 100 && o_req_ready !== 1'b1; n++) begin
            @(posedge i_ref_clk) #1;
        end
        @(posedge i_ref_clk) #1;
        i_req_valid = 1'b0;
        got         = 1'b0;
        for (n = 0; n < 200 && !got; n++) begin
            if (o_rsp_valid === 1'b1) got = 1'b1;
            else @(posedge i_ref_clk) #1;
        end
    endtask : do_req
    task automatic wr_rd(input op_t op, input logic [20:0] a, input logic [7:0] d, input logic [7:0] exp);
        do_req(op, 1'b0, a, d);
        chk({7'h0, got}, 8'h01);
        chk(o_rsp_data, 8'h00);
        do_req(OP_READ, 1'b0, a, 8'h00);
        chk(o_rsp_data, exp);
    endtask : wr_rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #2_000_000;
        error_cnt++;
        complete_run();
    end
    initial begin
        {i_resetn, i_req_valid, i_temp_unprotect, i_supply_ok, i_req} = '0;
        grp_prot    = 8'h20;
        @(posedge i_ref_clk) #1;
        // Supply ramps after time zero so the model sees a power-up
        i_supply_ok = 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 chk({7'h0, o_req_ready}, 8'h00);
        @(posedge i_ref_clk) #1;
        chk({7'h0, o_req_ready}, 8'h01);
        $display("reset test done");
        foreach (rows[i]) begin
            do_req(rows[i].op, rows[i].hv, rows[i].a, 8'h00);
            chk({7'h0, got}, 8'h01);
            chk(o_rsp_data, rows[i].exp);
            chk({7'h0, o_group_protected}, {7'h0, rows[i].prot});
        end
        $display("table test done");
        do_req(OP_RESET_CMD, 1'b0, 21'h0, CMD_RESET);
        chk({7'h0, got}, 8'h00);
        wr_rd(OP_PROGRAM, 21'h150010, 8'h5A, 8'hFF);
        i_temp_unprotect = 1'b1;
        wr_rd(OP_PROGRAM, 21'h150010, 8'h5A, 8'h5A);
        i_temp_unprotect = 1'b0;
        wr_rd(OP_ERASE_SECTOR, 21'h150010, 8'h00, 8'h5A);
        grp_prot = 8'h00;
        wr_rd(OP_ERASE_SECTOR, 21'h150010, 8'h00, 8'hFF);
        wr_rd(OP_PROGRAM, 21'h000033, 8'h3C, 8'h3C);
        $display("protection test done");
        fork
            begin
                repeat (8) @(posedge i_ref_clk);
                #1 i_supply_ok = 1'b0;
            end
        join_none
        do_req(OP_PROGRAM, 1'b0, 21'h000077, 8'h11);
        chk({7'h0, got}, 8'h00);
        chk({5'h0, o_pins.ce_n, o_pins.we_n, o_pins.oe_n}, 8'h07);
        i_supply_ok = 1'b1;
        do_req(OP_READ, 1'b0, 21'h000077, 8'h00);
        chk(o_rsp_data, 8'hFF);
        $display("lockout test done");
        complete_run();
    end
endmodule : flash_prot_host_tb_top
`default_nettype wire
